// >>> rtl/fault_pkg.sv
/*
 Shared register map, field positions, reset values and timing counts for the driver
 fault supervision block.
 Assumes a 20 MHz APB clock.
*/
package fault_pkg;
    localparam int unsigned clk_mhz = 20;
    // Blanking delays in nanoseconds; counts round up
    localparam int unsigned blank_ns_0 = 3200;
    localparam int unsigned blank_ns_1 = 1600;
    localparam int unsigned blank_ns_2 = 1200;
    localparam int unsigned blank_ns_3 = 800;
    localparam logic [7:0] blank_cyc_0 = 8'((blank_ns_0 * clk_mhz + 999) / 1000);
    localparam logic [7:0] blank_cyc_1 = 8'((blank_ns_1 * clk_mhz + 999) / 1000);
    localparam logic [7:0] blank_cyc_2 = 8'((blank_ns_2 * clk_mhz + 999) / 1000);
    localparam logic [7:0] blank_cyc_3 = 8'((blank_ns_3 * clk_mhz + 999) / 1000);
    localparam logic [1:0] short_retries = 2'h3;
    // Register byte addresses
    localparam logic [7:0] addr_ctrl = 8'h00;
    localparam logic [7:0] addr_status = 8'h04;
    localparam logic [7:0] addr_scale = 8'h08;
    // Control field positions
    localparam int unsigned f_off_time = 0;
    localparam int unsigned f_delay = 4;
    localparam int unsigned f_sens = 6;
    localparam int unsigned f_dis = 7;
    localparam int unsigned f_ls_en = 8;
    localparam int unsigned f_otsel = 9;
    localparam int unsigned f_lowsup = 10;
    localparam int unsigned f_slope = 12;
    // Status field positions
    localparam int unsigned s_short_a = 0;
    localparam int unsigned s_short_b = 1;
    localparam int unsigned s_sup_a = 2;
    localparam int unsigned s_sup_b = 3;
    localparam int unsigned s_gnd_a = 4;
    localparam int unsigned s_gnd_b = 5;
    localparam int unsigned s_ol_a = 6;
    localparam int unsigned s_ol_b = 7;
    localparam int unsigned s_warn = 8;
    localparam int unsigned s_shutdown = 9;
    localparam int unsigned s_disabled = 10;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [4:0] scale_reset = 5'h00;
    localparam logic [1:0] slope_max = 2'h3;
endpackage

// >>> rtl/short_detect.sv
/*
 One coil bridge short supervisor: blanking, three retries, shutdown latch.
 Assumes comparator inputs already synchronised to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module short_detect
    import fault_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic drv_disabled,
    input wire logic hs_enable,
    input wire logic ls_enable,
    input wire logic [7:0] blank_cycles,
    input wire logic hs_cmp,
    input wire logic ls_cmp,
    output logic bridge_off,
    output logic gnd_flag,
    output logic sup_flag,
    output logic short_flag
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [1:0] retries;
        logic off;
        logic gnd;
        logic sup;
        logic any;
    } sd_s;
    sd_s q, d;
    logic hit;

    always_comb
    begin
        d = q;
        hit = (hs_cmp && hs_enable) || (ls_cmp && ls_enable);
        if (hit && !q.off)
        begin
            // Comparator must stay active through the whole blanking window
            if (q.cnt >= blank_cycles)
            begin
                d.cnt = 8'h00;
                if (q.retries == short_retries)
                begin
                    d.off = 1'b1;
                    d.any = 1'b1;
                    d.gnd = q.gnd | (hs_cmp && hs_enable);
                    d.sup = q.sup | (ls_cmp && ls_enable);
                end
                else
                begin
                    d.retries = q.retries + 2'h1;
                end
            end
            else
            begin
                d.cnt = q.cnt + 8'h01;
            end
        end
        else
        begin
            d.cnt = 8'h00;
        end
        if (drv_disabled)
        begin
            d = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    assign bridge_off = q.off;
    assign gnd_flag = q.gnd;
    assign sup_flag = q.sup;
    assign short_flag = q.any;
endmodule
`default_nettype wire

// >>> rtl/open_load.sv
/*
 One coil open-load monitor: flags a polarity period with no chopper event.
 Assumes inputs on the pclk domain; the flag is indication only.
*/
`timescale 1ns/1ns
`default_nettype none
module open_load
    import fault_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic polarity,
    input wire logic chop_event,
    input wire logic low_current,
    output logic ol_flag
);
    typedef struct packed {
        logic pol;
        logic seen;
        logic flag;
    } ol_s;
    ol_s q, d;

    always_comb
    begin
        d = q;
        d.pol = polarity;
        if (polarity != q.pol)
        begin
            if (!low_current)
                d.flag = !q.seen;
            d.seen = chop_event;
        end
        else if (chop_event)
        begin
            d.seen = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    assign ol_flag = q.flag;
endmodule
`default_nettype wire

// >>> rtl/driver_fault_protection.sv
/*
 Driver fault supervision top: APB registers, short and open-load supervisors,
 thermal shutdown with release hysteresis and slope compensation.
 Assumes presetn is the undervoltage reset; analog comparator inputs are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module driver_fault_protection
    import fault_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hardware_driver_disable_pin,
    input wire logic [1:0] hs_short_cmp,
    input wire logic [1:0] ls_short_cmp,
    input wire logic [1:0] coil_polarity,
    input wire logic [1:0] chop_event,
    input wire logic [1:0] coil_low_current,
    input wire logic temp_above_100,
    input wire logic temp_above_120,
    input wire logic temp_above_136,
    input wire logic temp_above_150,
    output logic bridge_a_enable,
    output logic bridge_b_enable,
    output logic [1:0] high_side_gate_current,
    output logic high_side_detect_sensitivity,
    output logic low_supply_mode_enable,
    output logic resonance_damping_enable
);
    localparam int unsigned nsync = 10;

    typedef struct packed {
        logic [nsync-1:0] s1;
        logic [nsync-1:0] s2;
        logic [31:0] ctrl;
        logic [4:0] scale;
        logic warn;
        logic shut;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic en_a;
        logic en_b;
        logic [1:0] gate;
        logic sens;
        logic lowsup;
    } top_s;
    top_s q, d;

    logic [nsync-1:0] raw;
    logic [3:0] chopper_off_time_setting;
    logic [1:0] short_detect_blanking_delay;
    logic short_protection_disable;
    logic low_side_short_enable;
    logic thermal_threshold_select;
    logic [1:0] high_side_slope_code;
    logic drv_disabled;
    logic [7:0] blank_cycles;
    logic [1:0] off;
    logic [1:0] gnd;
    logic [1:0] sup;
    logic [1:0] any;
    logic [1:0] ol;
    logic temp_shut;
    logic [31:0] status;

    function automatic logic [7:0] blank_of(input logic [1:0] code);
        unique case (code)
            2'h0: blank_of = blank_cyc_0;
            2'h1: blank_of = blank_cyc_1;
            2'h2: blank_of = blank_cyc_2;
            2'h3: blank_of = blank_cyc_3;
        endcase
    endfunction

    function automatic logic slope_compensated(input logic [1:0] code);
        slope_compensated = (code == 2'h1) || (code == 2'h2);
    endfunction

    assign raw = {temp_above_150, temp_above_136, temp_above_120, temp_above_100,
                  ls_short_cmp, hs_short_cmp, hardware_driver_disable_pin, 1'b0};

    assign chopper_off_time_setting = q.ctrl[f_off_time +: 4];
    assign short_detect_blanking_delay = q.ctrl[f_delay +: 2];
    assign high_side_detect_sensitivity = q.sens;
    assign short_protection_disable = q.ctrl[f_dis];
    assign low_side_short_enable = q.ctrl[f_ls_en];
    assign thermal_threshold_select = q.ctrl[f_otsel];
    assign high_side_slope_code = q.ctrl[f_slope +: 2];
    assign low_supply_mode_enable = q.lowsup;
    assign resonance_damping_enable = q.lowsup;

    // Pin disable or zero off time both count as driver off
    assign drv_disabled = q.s2[1] || (chopper_off_time_setting == 4'h0);
    assign blank_cycles = blank_of(short_detect_blanking_delay);
    // Shutdown threshold chosen by the select bit
    assign temp_shut = thermal_threshold_select ? q.s2[8] : q.s2[9];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : coil
            short_detect u_short (
                .pclk(pclk),
                .presetn(presetn),
                .drv_disabled(drv_disabled),
                .hs_enable(!short_protection_disable),
                .ls_enable(low_side_short_enable && !short_protection_disable),
                .blank_cycles(blank_cycles),
                .hs_cmp(q.s2[2 + g]),
                .ls_cmp(q.s2[4 + g]),
                .bridge_off(off[g]),
                .gnd_flag(gnd[g]),
                .sup_flag(sup[g]),
                .short_flag(any[g])
            );
            open_load u_ol (
                .pclk(pclk),
                .presetn(presetn),
                .polarity(coil_polarity[g]),
                .chop_event(chop_event[g]),
                .low_current(coil_low_current[g]),
                .ol_flag(ol[g])
            );
        end
    endgenerate

    always_comb
    begin
        status = 32'h0000_0000;
        status[s_short_a] = any[0];
        status[s_short_b] = any[1];
        status[s_sup_a] = sup[0];
        status[s_sup_b] = sup[1];
        status[s_gnd_a] = gnd[0];
        status[s_gnd_b] = gnd[1];
        status[s_ol_a] = ol[0];
        status[s_ol_b] = ol[1];
        status[s_warn] = q.warn;
        status[s_shutdown] = q.shut;
        status[s_disabled] = drv_disabled;
    end

    always_comb
    begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        d.warn = q.s2[6];
        if (temp_shut)
            d.shut = 1'b1;
        else if (!q.s2[7])
            d.shut = 1'b0;
        // Bridge enables ignore open-load state entirely
        d.en_a = !drv_disabled && !q.shut && !temp_shut && !off[0];
        d.en_b = !drv_disabled && !q.shut && !temp_shut && !off[1];
        d.gate = high_side_slope_code;
        if (slope_compensated(high_side_slope_code) && q.warn)
            d.gate = high_side_slope_code + 2'h1;
        d.sens = q.ctrl[f_sens];
        d.lowsup = q.ctrl[f_lowsup];
        // One wait state: answer in the second access cycle
        d.ready = 1'b0;
        d.err = 1'b0;
        if (psel && penable && !q.ready)
        begin
            d.ready = 1'b1;
            d.rdata = 32'h0000_0000;
            unique case (paddr)
                addr_ctrl:
                begin
                    if (pwrite)
                        d.ctrl = {18'h0, pwdata[13:0]};
                    d.rdata = q.ctrl;
                end
                addr_status:
                begin
                    d.rdata = status;
                    d.err = pwrite;
                end
                addr_scale:
                begin
                    if (pwrite)
                        d.scale = pwdata[4:0];
                    d.rdata = {27'h0, q.scale};
                end
                default:
                begin
                    d.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.ctrl <= ctrl_reset;
            q.scale <= scale_reset;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.err;
    assign bridge_a_enable = q.en_a;
    assign bridge_b_enable = q.en_b;
    assign high_side_gate_current = q.gate;
endmodule
`default_nettype wire

// >>> tb/coil_bridge_model.sv
/*
 Far side model: coil bridges, their short comparators and the die temperature sensor.
 Assumes the bench sets fault and temperature levels on pclk edges.
*/
`timescale 1ns/1ns
`default_nettype none
module coil_bridge_model (
    input wire logic [1:0] bridge_on,
    input wire logic [1:0] gnd_fault,
    input wire logic [1:0] sup_fault,
    input wire logic [7:0] temp_c,
    output logic [1:0] hs_short_cmp,
    output logic [1:0] ls_short_cmp,
    output logic [3:0] temp_above
);
    // A short only draws current while its bridge drives, so a latched bridge goes quiet
    assign hs_short_cmp = gnd_fault & bridge_on;
    assign ls_short_cmp = sup_fault & bridge_on;
    assign temp_above = {temp_c >= 8'h96, temp_c >= 8'h88, temp_c >= 8'h78, temp_c >= 8'h64};
endmodule
`default_nettype wire

// >>> tb/fault_chk_chk.sv
/*
 Port checks for the fault supervision top, bound to every instance.
 Assumes pclk is the only clock; windows allow for the two-flop input syncs.
*/
`timescale 1ns/1ns
`default_nettype none
module fault_chk
    import fault_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hardware_driver_disable_pin,
    input wire logic [1:0] hs_short_cmp,
    input wire logic [1:0] ls_short_cmp,
    input wire logic temp_above_120,
    input wire logic temp_above_136,
    input wire logic temp_above_150,
    input wire logic bridge_a_enable,
    input wire logic bridge_b_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence access_wait;
        psel && penable && !pready;
    endsequence
    sequence quiet_b;
        bridge_b_enable && !hs_short_cmp[1] && !ls_short_cmp[1] && !temp_above_136 && !psel;
    endsequence
    sequence hot_then_warm;
        temp_above_150 [*8] ##1 temp_above_120 [*8];
    endsequence
    chk_apb_answer: assert property (access_wait |=> pready)
        else $error("no pready after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_pair: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_hole_read: assert property (pready && !pwrite && paddr > addr_scale |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    chk_status_write: assert property (pready && pwrite && paddr == addr_status |-> pslverr)
        else $error("status write not refused");
    chk_pin_off: assert property (hardware_driver_disable_pin [*7] |-> !bridge_a_enable && !bridge_b_enable)
        else $error("bridge on while disable pin high");
    chk_hot_off: assert property (temp_above_150 [*7] |-> !bridge_a_enable && !bridge_b_enable)
        else $error("bridge on above shutdown level");
    chk_hot_hold: assert property (hot_then_warm |-> !bridge_a_enable && !bridge_b_enable)
        else $error("bridge back on above release level");
    chk_retry_blank: assert property ($rose(hs_short_cmp[0]) && bridge_a_enable ##1 (!psel && !hardware_driver_disable_pin) [*8] |-> bridge_a_enable)
        else $error("short tripped before retries");
    chk_bridge_alone: assert property ($fell(bridge_a_enable) ##0 quiet_b |=> bridge_b_enable)
        else $error("healthy bridge switched off");
endmodule
bind driver_fault_protection fault_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .hardware_driver_disable_pin, .hs_short_cmp, .ls_short_cmp,
    .temp_above_120, .temp_above_136, .temp_above_150, .bridge_a_enable, .bridge_b_enable);
`default_nettype wire

// >>> tb/tb_top.sv
/*
 Self-checking bench for the fault supervision block: registers, shorts, thermal, open load.
 Assumes fault_pkg, the design and the bridge model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fault_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, re, hardware_driver_disable_pin = 1'h0;
    logic [1:0] coil_polarity = 2'h0, chop_event = 2'h0, coil_low_current = 2'h0;
    logic [1:0] gnd_fault = 2'h0, sup_fault = 2'h0, hs_short_cmp, ls_short_cmp;
    logic [1:0] high_side_gate_current;
    logic [7:0] temp_c = 8'h19;
    logic [3:0] temp_above;
    logic bridge_a_enable, bridge_b_enable, high_side_detect_sensitivity;
    logic low_supply_mode_enable, resonance_damping_enable;
    logic [6:0] snap;
    int fail_count = 0;
    int samples_checked = 0;
    driver_fault_protection DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hardware_driver_disable_pin, .hs_short_cmp, .ls_short_cmp,
        .coil_polarity, .chop_event, .coil_low_current,
        .temp_above_100(temp_above[0]), .temp_above_120(temp_above[1]),
        .temp_above_136(temp_above[2]), .temp_above_150(temp_above[3]),
        .bridge_a_enable, .bridge_b_enable, .high_side_gate_current,
        .high_side_detect_sensitivity, .low_supply_mode_enable, .resonance_damping_enable);
    coil_bridge_model far (.bridge_on({bridge_b_enable, bridge_a_enable}), .gnd_fault,
        .sup_fault, .temp_c, .hs_short_cmp, .ls_short_cmp, .temp_above);
    initial forever #25 pclk = ~pclk;
    // Outputs are judged from the value settled before each edge
    always @(negedge pclk) snap <= {resonance_damping_enable, low_supply_mode_enable,
        high_side_detect_sensitivity, high_side_gate_current, bridge_b_enable, bridge_a_enable};
    task automatic summarize();
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Answer is taken at the rising edge where pready is seen high, then released
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        rv = prdata;
        re = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1)
        begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic t_regs();
        apb(1'h0, addr_ctrl, 32'h0);
        chk("ctrl_rst", rv, 32'h0);
        apb(1'h0, addr_status, 32'h0);
        chk("stat_rst", rv, 32'h0000_0400);
        apb(1'h0, 8'h0c, 32'h0);
        chk("hole", {re, rv[30:0]}, 32'h8000_0000);
        apb(1'h1, addr_status, 32'h0000_07ff);
        chk("ro_err", re, 32'h1);
        apb(1'h1, addr_scale, 32'h0000_001f);
        apb(1'h1, addr_ctrl, 32'h0000_3441);
        cyc(6);
        chk("outputs", snap, 32'h7f);
        presetn <= 1'h0;
        cyc(2);
        chk("uv_outputs", snap, 32'h0);
        presetn <= 1'h1;
        apb(1'h0, addr_scale, 32'h0);
        chk("scale_uv", rv, 32'h0);
        apb(1'h0, addr_ctrl, 32'h0);
        chk("ctrl_uv", rv, 32'h0);
    endtask
    task automatic t_short();
        int n;
        int ns [4] = '{3200, 1600, 1200, 800};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'h1, addr_ctrl, 32'h0000_0101 | (i << f_delay));
            cyc(8);
            chk("bridges_on", snap[1:0], 32'h3);
            if (i[1])
                sup_fault[i[0]] <= 1'h1;
            else
                gnd_fault[i[0]] <= 1'h1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (snap[i[0]] && n < 2000);
            chk("trip_time", n >= 4 * (ns[i] * 20 / 1000 + 1) &&
                n <= 4 * (ns[i] * 20 / 1000 + 1) + 6, 32'h1);
            chk("other_on", snap[!i[0]], 32'h1);
            apb(1'h0, addr_status, 32'h0);
            chk("flags", rv, (32'h1 << i[0]) | (32'h1 << ((i[1] ? 2 : 4) + i[0])));
            chk("latched", snap[i[0]], 32'h0);
            gnd_fault <= 2'h0;
            sup_fault <= 2'h0;
            if (i[0])
                hardware_driver_disable_pin <= 1'h1;
            else
                apb(1'h1, addr_ctrl, 32'h0);
            cyc(6);
            apb(1'h0, addr_status, 32'h0);
            chk("flags_clr", rv, 32'h0000_0400);
            hardware_driver_disable_pin <= 1'h0;
        end
    endtask
    task automatic t_quiet();
        apb(1'h1, addr_ctrl, 32'h0000_0181);
        gnd_fault <= 2'h1;
        cyc(300);
        chk("dis_bit", snap[1:0], 32'h3);
        gnd_fault <= 2'h0;
        apb(1'h1, addr_ctrl, 32'h0000_0001);
        sup_fault <= 2'h2;
        cyc(300);
        chk("ls_off", snap[1:0], 32'h3);
        sup_fault <= 2'h0;
        apb(1'h0, addr_status, 32'h0);
        chk("quiet_flags", rv, 32'h0);
    endtask
    task automatic t_thermal();
        apb(1'h1, addr_ctrl, 32'h0000_1201);
        temp_c <= 8'h8c; // 140 C trips the low threshold only
        cyc(10);
        chk("shut_off", snap[3:0], 32'h8);
        apb(1'h0, addr_status, 32'h0);
        chk("shut_flags", rv & 32'h0000_0300, 32'h0000_0300);
        temp_c <= 8'h6e; // 110 C
        cyc(10);
        chk("shut_release", snap[1:0], 32'h3);
        apb(1'h1, addr_ctrl, 32'h0000_3001);
        temp_c <= 8'h8c;
        cyc(10);
        chk("shut_high_thr", snap[3:0], 32'hf);
        temp_c <= 8'h9b; // 155 C
        cyc(10);
        temp_c <= 8'h7d; // 125 C
        cyc(10);
        chk("shut_hold", snap[1:0], 32'h0);
        apb(1'h1, addr_ctrl, 32'h0000_2001);
        temp_c <= 8'h6e;
        cyc(10);
        chk("slope_two", snap[3:0], 32'hf);
        temp_c <= 8'h19;
    endtask
    task automatic t_open_load();
        logic [3:0] ch, lw, ex;
        ch = 4'hd;
        lw = 4'h4;
        ex = 4'h6;
        apb(1'h1, addr_ctrl, 32'h0000_0001);
        coil_polarity <= 2'h3;
        cyc(4);
        for (int k = 0; k < 4; k++)
        begin
            chop_event <= {2{ch[k]}};
            coil_low_current <= {2{lw[k]}};
            cyc(1);
            chop_event <= 2'h0;
            cyc(4);
            coil_polarity <= ~coil_polarity;
            cyc(2);
            coil_low_current <= 2'h0;
            apb(1'h0, addr_status, 32'h0);
            chk("open_load", rv[7:6], {2{ex[k]}});
            chk("ol_no_action", snap[1:0], 32'h3);
        end
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_short();
        t_quiet();
        t_thermal();
        t_open_load();
        summarize();
    end
    initial
    begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire
